// ---- rtl/itc_pkg.sv ----
// Constants and carrier types for the interrupt, trap and event-transfer controller
package itc_pkg;
  localparam int NUM_SRC = 17;
  localparam int NUM_CHAN = 8;
  localparam int NUM_EXT = 4;
  localparam int PRIO_W = 4;
  localparam int TRAP_W = 7;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 8;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RESET = 24'h000000;
  localparam logic [15:0] LIMIT_UPPER_RESET = 16'hFA00;
  localparam logic [15:0] LIMIT_LOWER_RESET = 16'hFC00;
  // Trap numbers; vector address is four times the trap number
  localparam logic [TRAP_W-1:0] TRAP_NONMASKABLE = 7'h02;
  localparam logic [TRAP_W-1:0] TRAP_STACK_OVER = 7'h04;
  localparam logic [TRAP_W-1:0] TRAP_STACK_UNDER = 7'h06;
  localparam logic [TRAP_W-1:0] TRAP_CLASS_B = 7'h0A;
  localparam int VEC_SHIFT = 2;
  // Trap flag register bit positions
  localparam int TF_NONMASKABLE = 15;
  localparam int TF_STACK_OVER = 14;
  localparam int TF_STACK_UNDER = 13;
  localparam int TF_UNDEF_OPCODE = 7;
  localparam int TF_PROT_FAULT = 3;
  localparam int TF_ILL_OPERAND = 2;
  localparam int TF_ILL_FETCH = 1;
  localparam int TF_ILL_BUS = 0;
  // Per-source trap numbers: ext0..3, timers 2..6, capture, serial x4, pwm, ssp, pll
  localparam logic [NUM_SRC*TRAP_W-1:0] SRC_TRAP = {
    7'h43, 7'h41, 7'h3F, 7'h2C, 7'h2B, 7'h47, 7'h2A, 7'h27,
    7'h26, 7'h25, 7'h24, 7'h23, 7'h22, 7'h1B, 7'h1A, 7'h19, 7'h18};
  // Service level encoding: 0..15 interrupt levels, above that trap classes
  localparam logic [5:0] LVL_CLASS_B = 6'h10;
  localparam logic [5:0] LVL_CLASS_A = 6'h20;

  typedef enum logic [1:0] {EDGE_RISE = 2'h1, EDGE_FALL = 2'h2, EDGE_BOTH = 2'h3} itc_edge_t;

  typedef struct packed {
    logic req_set;
    logic enable;
    logic route_chan;
    logic [2:0] chan;
    logic [PRIO_W-1:0] prio;
  } itc_src_cfg_t;

  typedef struct packed {
    logic continuous;
    logic word;
    logic inc_dst;
    logic [CNT_W-1:0] count;
    logic [ADDR_W-1:0] src_ptr;
    logic [ADDR_W-1:0] dst_ptr;
  } itc_chan_cfg_t;

  typedef struct packed {
    logic valid;
    logic word;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
  } itc_move_t;
endpackage : itc_pkg

// ---- rtl/itc_controller.sv ----
// Interrupt, trap and event-transfer channel controller
// Function
// - Each source is routed to vectored interrupt or event channel per configuration.
// - Each source has request flag, enable flag and priority field.
// - Priority field selects one of sixteen levels for arbitration.
// - Accepted service is preempted only by strictly higher priority.
// - Interrupt branches to source vector at four times its trap number.
// - Seventeen sources, each with its own vector and trap number.
// - Event-channel service steals exactly one cycle from the CPU.
// - Channel moves byte or word, then bumps source or destination pointer.
// - Transfer counter decrements per service unless continuous mode.
// - Counter reaching zero turns the source's next request into a standard interrupt to its vector.
// - Eight independent event transfer channels.
// - Fast external inputs detect rising, falling or both edges.
// - Software trap 00h to 7Fh vectors at four times number, current priority.
// - Hardware exceptions branch immediately, non-maskable, to dedicated vector.
// - Each hardware trap sets its own trap flag bit.
// - Hardware traps preempt unless equal or higher trap running; interrupts never preempt traps.
// - Every stack access compares stack pointer against both limits.
// - Class A traps: nonmaskable 02h, overflow 04h, underflow 06h, priority II.
// - Class B traps share trap 0Ah at priority I, five causes.
`timescale 1ns/100ps
module itc_controller #(
  parameter int NUM_SRC = itc_pkg::NUM_SRC,
  parameter int NUM_CHAN = itc_pkg::NUM_CHAN
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] periph_req,
  input wire logic [itc_pkg::NUM_EXT-1:0] ext_pin,
  input wire itc_pkg::itc_edge_t [itc_pkg::NUM_EXT-1:0] ext_edge_sel,
  input wire itc_pkg::itc_src_cfg_t [NUM_SRC-1:0] src_cfg,
  input wire logic [NUM_SRC-1:0] src_cfg_we,
  input wire itc_pkg::itc_chan_cfg_t [NUM_CHAN-1:0] chan_cfg,
  input wire logic [NUM_CHAN-1:0] chan_cfg_we,
  input wire logic [5:0] cpu_level,
  input wire logic cpu_ack,
  input wire logic swtrap_req,
  input wire logic [itc_pkg::TRAP_W-1:0] swtrap_num,
  input wire logic nmi_pin,
  input wire logic [4:0] class_b_event,
  input wire logic stack_access,
  input wire logic [15:0] stack_pointer_reg,
  input wire logic [15:0] limit_wdata,
  input wire logic stack_upper_limit_we,
  input wire logic stack_lower_limit_we,
  input wire logic [15:0] trap_flag_clear,
  output logic irq_valid,
  output logic [itc_pkg::ADDR_W-1:0] irq_vector,
  output logic [5:0] irq_level,
  output logic irq_is_trap,
  output itc_pkg::itc_move_t move,
  output logic [NUM_SRC-1:0] req_flag,
  output logic [NUM_SRC-1:0] enable_flag,
  output logic [NUM_CHAN*itc_pkg::CNT_W-1:0] chan_count,
  output logic [15:0] trap_flag_register
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_OFFER = 2'b01, ST_MOVE = 2'b10} itc_state_t;

  function automatic logic [itc_pkg::ADDR_W-1:0] vec_of(input logic [itc_pkg::TRAP_W-1:0] n);
    vec_of = {{(itc_pkg::ADDR_W-itc_pkg::TRAP_W-itc_pkg::VEC_SHIFT){1'b0}}, n, 2'b00};
  endfunction : vec_of

  function automatic logic [itc_pkg::TRAP_W-1:0] src_trap(input int i);
    src_trap = itc_pkg::SRC_TRAP[i*itc_pkg::TRAP_W +: itc_pkg::TRAP_W];
  endfunction : src_trap

  itc_state_t state_q;
  logic [NUM_SRC-1:0] req_q;
  logic [NUM_SRC-1:0] en_q;
  logic [NUM_SRC-1:0] route_q;
  logic [2:0] chan_q [NUM_SRC];
  logic [itc_pkg::PRIO_W-1:0] prio_q [NUM_SRC];
  logic [NUM_CHAN-1:0] cont_q;
  logic [NUM_CHAN-1:0] word_q;
  logic [NUM_CHAN-1:0] incd_q;
  logic [itc_pkg::CNT_W-1:0] cnt_q [NUM_CHAN];
  logic [itc_pkg::ADDR_W-1:0] sptr_q [NUM_CHAN];
  logic [itc_pkg::ADDR_W-1:0] dptr_q [NUM_CHAN];
  logic [NUM_SRC-1:0] zero_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] tfr_q;
  logic [itc_pkg::NUM_EXT-1:0] ext_s1_q;
  logic [itc_pkg::NUM_EXT-1:0] ext_s2_q;
  logic [itc_pkg::NUM_EXT-1:0] ext_s3_q;
  logic [itc_pkg::NUM_EXT-1:0] ext_lvl_q;
  logic [2:0] nmi_sync_q;
  logic nmi_lvl_q;
  logic [4:0] sel_q;
  logic sel_chan_q;
  logic sel_valid_q;
  logic [NUM_SRC-1:0] ext_evt;
  logic nmi_evt;
  logic [NUM_SRC-1:0] live;
  logic [4:0] best_idx;
  logic [itc_pkg::PRIO_W-1:0] best_prio;
  logic best_any;
  logic overflow_hit;
  logic underflow_hit;
  logic [15:0] tf_set;
  logic trap_a;
  logic trap_b;
  logic [NUM_SRC-1:0] clr_vec;

  // Pin inputs: three-stage sync, change accepted when stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
      ext_lvl_q <= '0;
      nmi_sync_q <= 3'h0;
      nmi_lvl_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      ext_lvl_q <= (ext_s2_q & ext_s3_q) | (ext_lvl_q & (ext_s2_q | ext_s3_q));
      nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin};
      if (nmi_sync_q[1] == nmi_sync_q[2]) begin
        nmi_lvl_q <= nmi_sync_q[2];
      end
    end
  end

  always_comb begin
    ext_evt = '0;
    for (int i = 0; i < itc_pkg::NUM_EXT; i++) begin
      logic nxt;
      nxt = (ext_s2_q[i] & ext_s3_q[i]) | (ext_lvl_q[i] & (ext_s2_q[i] | ext_s3_q[i]));
      ext_evt[i] = ((nxt & ~ext_lvl_q[i]) & ext_edge_sel[i][0])
                 | ((~nxt & ext_lvl_q[i]) & ext_edge_sel[i][1]);
    end
  end

  // Falling edge of the filtered nonmaskable level raises the trap
  assign nmi_evt = nmi_lvl_q & (nmi_sync_q[1] == nmi_sync_q[2]) & ~nmi_sync_q[2];

  assign overflow_hit = stack_access & (stack_pointer_reg < upper_q);
  assign underflow_hit = stack_access & (stack_pointer_reg > lower_q);

  always_comb begin
    tf_set = '0;
    tf_set[itc_pkg::TF_NONMASKABLE] = nmi_evt;
    tf_set[itc_pkg::TF_STACK_OVER] = overflow_hit;
    tf_set[itc_pkg::TF_STACK_UNDER] = underflow_hit;
    tf_set[itc_pkg::TF_UNDEF_OPCODE] = class_b_event[4];
    tf_set[itc_pkg::TF_PROT_FAULT] = class_b_event[3];
    tf_set[itc_pkg::TF_ILL_OPERAND] = class_b_event[2];
    tf_set[itc_pkg::TF_ILL_FETCH] = class_b_event[1];
    tf_set[itc_pkg::TF_ILL_BUS] = class_b_event[0];
  end

  // Set beats software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      tfr_q <= 16'h0000;
      upper_q <= itc_pkg::LIMIT_UPPER_RESET;
      lower_q <= itc_pkg::LIMIT_LOWER_RESET;
    end else begin
      tfr_q <= (tfr_q & ~trap_flag_clear) | tf_set;
      if (stack_upper_limit_we) begin
        upper_q <= limit_wdata;
      end
      if (stack_lower_limit_we) begin
        lower_q <= limit_wdata;
      end
    end
  end

  assign trap_a = |tfr_q[itc_pkg::TF_NONMASKABLE:itc_pkg::TF_STACK_UNDER];
  assign trap_b = |{tfr_q[itc_pkg::TF_UNDEF_OPCODE], tfr_q[itc_pkg::TF_PROT_FAULT:0]};

  // Arbitration over pending, enabled sources
  always_comb begin
    best_idx = '0;
    best_prio = '0;
    best_any = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      live[i] = req_q[i] & en_q[i];
      if (live[i] && (!best_any || prio_q[i] > best_prio)) begin
        best_any = 1'b1;
        best_prio = prio_q[i];
        best_idx = 5'(i);
      end
    end
  end

  // auto clear on acceptance or finished move
  always_comb begin
    clr_vec = '0;
    clr_vec[sel_q] = (state_q == ST_OFFER && cpu_ack && !sel_chan_q) || state_q == ST_MOVE;
  end

  // Source control: request, enable, priority, routing
  always_ff @(posedge clock) begin
    if (rst) begin
      req_q <= '0;
      en_q <= '0;
      route_q <= '0;
      for (int i = 0; i < NUM_SRC; i++) begin
        chan_q[i] <= 3'h0;
        prio_q[i] <= itc_pkg::PRIO_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (src_cfg_we[i]) begin
          en_q[i] <= src_cfg[i].enable;
          route_q[i] <= src_cfg[i].route_chan;
          chan_q[i] <= src_cfg[i].chan;
          prio_q[i] <= src_cfg[i].prio;
        end
        // Edge events above the pin sources stay low; a new request beats the clear
        req_q[i] <= ext_evt[i] | periph_req[i] | (src_cfg_we[i] & src_cfg[i].req_set)
                  | (req_q[i] & ~clr_vec[i]);
      end
    end
  end

  // Service sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      sel_q <= 5'h00;
      sel_chan_q <= 1'b0;
      sel_valid_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (best_any && {2'b00, best_prio} > cpu_level && !trap_a && !trap_b) begin
            sel_q <= best_idx;
            // exhausted channel falls back to vectored service
            sel_chan_q <= route_q[best_idx] & ~zero_q[best_idx];
            sel_valid_q <= 1'b1;
            state_q <= (route_q[best_idx] & ~zero_q[best_idx]) ? ST_MOVE : ST_OFFER;
          end
        end
        ST_OFFER: begin
          if (cpu_ack) begin
            sel_valid_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_MOVE: begin
          sel_valid_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cont_q <= '0;
      word_q <= '0;
      incd_q <= '0;
      zero_q <= '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
        cnt_q[c] <= itc_pkg::CNT_RESET;
        sptr_q[c] <= itc_pkg::PTR_RESET;
        dptr_q[c] <= itc_pkg::PTR_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (chan_cfg_we[c]) begin
          cont_q[c] <= chan_cfg[c].continuous;
          word_q[c] <= chan_cfg[c].word;
          incd_q[c] <= chan_cfg[c].inc_dst;
          cnt_q[c] <= chan_cfg[c].count;
          sptr_q[c] <= chan_cfg[c].src_ptr;
          dptr_q[c] <= chan_cfg[c].dst_ptr;
        end else if (state_q == ST_MOVE && chan_q[sel_q] == 3'(c)) begin
          if (incd_q[c]) begin
            dptr_q[c] <= dptr_q[c] + (word_q[c] ? 24'h000002 : 24'h000001);
          end else begin
            sptr_q[c] <= sptr_q[c] + (word_q[c] ? 24'h000002 : 24'h000001);
          end
          if (!cont_q[c]) begin
            cnt_q[c] <= cnt_q[c] - 8'h01;
          end
        end
      end
      for (int i = 0; i < NUM_SRC; i++) begin
        if (state_q == ST_MOVE && sel_q == 5'(i) && !cont_q[chan_q[i]]
            && cnt_q[chan_q[i]] == 8'h01) begin
          zero_q[i] <= 1'b1;
        end else if (src_cfg_we[i] || (state_q == ST_OFFER && cpu_ack && sel_q == 5'(i))) begin
          zero_q[i] <= 1'b0;
        end
      end
    end
  end

  // Output register: vector offer, move descriptor and status
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_valid <= 1'b0;
      irq_vector <= '0;
      irq_level <= 6'h00;
      irq_is_trap <= 1'b0;
      move <= '0;
      req_flag <= '0;
      enable_flag <= '0;
      chan_count <= '0;
      trap_flag_register <= 16'h0000;
    end else begin
      move.valid <= 1'b0;
      irq_valid <= 1'b0;
      if (trap_a && cpu_level < itc_pkg::LVL_CLASS_A) begin
        irq_valid <= 1'b1;
        irq_is_trap <= 1'b1;
        irq_level <= itc_pkg::LVL_CLASS_A;
        irq_vector <= tfr_q[itc_pkg::TF_NONMASKABLE] ? vec_of(itc_pkg::TRAP_NONMASKABLE)
                    : tfr_q[itc_pkg::TF_STACK_OVER] ? vec_of(itc_pkg::TRAP_STACK_OVER)
                    : vec_of(itc_pkg::TRAP_STACK_UNDER);
      end else if (trap_b && cpu_level < itc_pkg::LVL_CLASS_B) begin
        irq_valid <= 1'b1;
        irq_is_trap <= 1'b1;
        irq_level <= itc_pkg::LVL_CLASS_B;
        irq_vector <= vec_of(itc_pkg::TRAP_CLASS_B);
      end else if (swtrap_req) begin
        irq_valid <= 1'b1;
        irq_is_trap <= 1'b1;
        irq_level <= cpu_level;
        irq_vector <= vec_of(swtrap_num);
      end else if (state_q == ST_OFFER && !(cpu_ack && irq_valid)) begin
        irq_valid <= 1'b1;
        irq_is_trap <= 1'b0;
        irq_level <= {2'b00, prio_q[sel_q]};
        irq_vector <= vec_of(src_trap(int'(sel_q)));
      end
      if (state_q == ST_MOVE) begin
        move.valid <= 1'b1;
        move.word <= word_q[chan_q[sel_q]];
        move.src <= sptr_q[chan_q[sel_q]];
        move.dst <= dptr_q[chan_q[sel_q]];
      end
      req_flag <= req_q;
      enable_flag <= en_q;
      trap_flag_register <= tfr_q;
      for (int c = 0; c < NUM_CHAN; c++) begin
        chan_count[c*itc_pkg::CNT_W +: itc_pkg::CNT_W] <= cnt_q[c];
      end
    end
  end
endmodule : itc_controller

// ---- sim/itc_controller_props.sv ----
// Port checker for the interrupt, trap and event-transfer controller
`timescale 1ns/100ps
module itc_controller_props #(
  parameter int NUM_SRC = 17,
  parameter int NUM_CHAN = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] cpu_level,
  input wire logic cpu_ack,
  input wire logic swtrap_req,
  input wire logic [4:0] class_b_event,
  input wire logic [15:0] trap_flag_clear,
  input wire logic irq_valid,
  input wire logic [itc_pkg::ADDR_W-1:0] irq_vector,
  input wire logic [5:0] irq_level,
  input wire logic irq_is_trap,
  input wire itc_pkg::itc_move_t move,
  input wire logic [15:0] trap_flag_register
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] kept_q;
  logic [15:0] clr_q;
  logic sw_seen_q;
  // Flag output lags the clear by two cycles, so mask with the delayed clear
  always_ff @(posedge clock) clr_q <= trap_flag_clear;
  always_ff @(posedge clock) kept_q <= trap_flag_register & ~clr_q;
  // Software traps run at the current level, so they leave the level check
  always_ff @(posedge clock) sw_seen_q <= !rst && (sw_seen_q || swtrap_req);
  property p_move_one; move.valid |=> !move.valid; endproperty
  a_move_one: assert property (p_move_one) else $error("move lasted too long");
  property p_ack_end; irq_valid && cpu_ack && !irq_is_trap |=> !irq_valid; endproperty
  a_ack_end: assert property (p_ack_end) else $error("offer kept after ack");
  property p_vec_word; irq_valid |-> irq_vector[1:0] == 2'h0; endproperty
  a_vec_word: assert property (p_vec_word) else $error("vector not aligned");
  property p_above; $rose(irq_valid) && !irq_is_trap && !sw_seen_q |-> irq_level > cpu_level;
  endproperty
  a_above: assert property (p_above) else $error("offer not above cpu level");
  property p_lvl16; $rose(irq_valid) && !irq_is_trap |-> irq_level <= 6'h0F; endproperty
  a_lvl16: assert property (p_lvl16) else $error("level out of range");
  property p_trap_first; $rose(irq_valid) && trap_flag_register != 16'h0000 |-> irq_is_trap;
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("interrupt during trap");
  property p_flag_keep; (trap_flag_register & kept_q) == kept_q; endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("trap flag lost");
  property p_undef_flag; class_b_event[4] |-> ##[1:4] trap_flag_register[7]; endproperty
  a_undef_flag: assert property (p_undef_flag) else $error("opcode flag missing");
  property p_class_a;
    irq_valid && irq_level == 6'h20 |-> irq_vector inside {24'h000008, 24'h000010, 24'h000018};
  endproperty
  a_class_a: assert property (p_class_a) else $error("class A vector wrong");
  property p_class_b; irq_valid && irq_level == 6'h10 |-> irq_vector == 24'h000028; endproperty
  a_class_b: assert property (p_class_b) else $error("class B vector wrong");
endmodule : itc_controller_props
bind itc_controller itc_controller_props #(.NUM_SRC(NUM_SRC), .NUM_CHAN(NUM_CHAN))
  itc_controller_props_inst (.clock(clock), .rst(rst), .cpu_level(cpu_level),
  .cpu_ack(cpu_ack), .swtrap_req(swtrap_req), .class_b_event(class_b_event),
  .trap_flag_clear(trap_flag_clear), .irq_valid(irq_valid), .irq_vector(irq_vector),
  .irq_level(irq_level), .irq_is_trap(irq_is_trap), .move(move),
  .trap_flag_register(trap_flag_register));

// ---- sim/itc_cpu_model.sv ----
// CPU side model that accepts standing offers after a chosen delay
`timescale 1ns/100ps
module itc_cpu_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic irq_valid,
  input wire logic [3:0] ack_delay,
  output logic cpu_ack
);
  logic [3:0] wait_q = 4'h0;
  initial cpu_ack = 1'b0;
  // One-cycle ack, only while an offer stands
  always @(negedge clock) begin
    cpu_ack <= 1'b0;
    if (rst || !irq_valid || cpu_ack) begin
      wait_q <= 4'h0;
    end else if (wait_q == ack_delay) begin
      cpu_ack <= 1'b1;
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : itc_cpu_model

// ---- sim/itc_controller_tb_top.sv ----
// Self-checking bench for the interrupt, trap and event-transfer controller
`timescale 1ns/100ps
module itc_controller_tb_top;
  localparam logic [23:0] VEC [17] = '{24'h60, 24'h64, 24'h68, 24'h6C, 24'h88, 24'h8C,
    24'h90, 24'h94, 24'h98, 24'h9C, 24'hA8, 24'h11C, 24'hAC, 24'hB0, 24'hFC, 24'h104, 24'h10C};
  localparam int TFB [5] = '{0, 1, 2, 3, 7};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [16:0] periph_req = '0;
  logic [3:0] ext_pin = '0;
  itc_pkg::itc_edge_t [3:0] ext_edge_sel = '{4{itc_pkg::EDGE_RISE}};
  itc_pkg::itc_src_cfg_t [16:0] src_cfg = '0;
  logic [16:0] src_cfg_we = '0;
  itc_pkg::itc_chan_cfg_t [7:0] chan_cfg = '0;
  logic [7:0] chan_cfg_we = '0;
  logic [5:0] cpu_level = '0;
  logic cpu_ack;
  logic swtrap_req = 1'b0;
  logic [6:0] swtrap_num = '0;
  logic nmi_pin = 1'b1;
  logic [4:0] class_b_event = '0;
  logic stack_access = 1'b0;
  logic [15:0] stack_pointer_reg = 16'hFB00;
  logic [15:0] limit_wdata = 16'hFA00;
  logic stack_upper_limit_we = 1'b0;
  logic stack_lower_limit_we = 1'b0;
  logic [15:0] trap_flag_clear = '0;
  logic [3:0] ack_delay = 4'h2;
  logic irq_valid, irq_is_trap;
  logic [23:0] irq_vector;
  logic [5:0] irq_level;
  itc_pkg::itc_move_t move;
  logic [16:0] req_flag, enable_flag;
  logic [63:0] chan_count;
  logic [15:0] trap_flag_register;
  int num_errors = 0;
  int comparisons = 0;
  always #12.5 clock = ~clock;
  itc_controller itc_controller_inst (.clock(clock), .rst(rst), .periph_req(periph_req),
    .ext_pin(ext_pin), .ext_edge_sel(ext_edge_sel), .src_cfg(src_cfg),
    .src_cfg_we(src_cfg_we), .chan_cfg(chan_cfg), .chan_cfg_we(chan_cfg_we),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .swtrap_req(swtrap_req),
    .swtrap_num(swtrap_num), .nmi_pin(nmi_pin), .class_b_event(class_b_event),
    .stack_access(stack_access), .stack_pointer_reg(stack_pointer_reg),
    .limit_wdata(limit_wdata), .stack_upper_limit_we(stack_upper_limit_we),
    .stack_lower_limit_we(stack_lower_limit_we),
    .trap_flag_clear(trap_flag_clear), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_level(irq_level), .irq_is_trap(irq_is_trap), .move(move), .req_flag(req_flag),
    .enable_flag(enable_flag), .chan_count(chan_count),
    .trap_flag_register(trap_flag_register));
  itc_cpu_model itc_cpu_model_inst (.clock(clock), .rst(rst), .irq_valid(irq_valid),
    .ack_delay(ack_delay), .cpu_ack(cpu_ack));
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : cmp_val
  // Which 0 waits for an offer, 1 for a move
  task automatic wait_for(input int which);
    for (int i = 0; i < 40; i++) begin
      @(negedge clock);
      if ((which == 0) ? (irq_valid === 1'b1) : (move.valid === 1'b1)) return;
    end
    num_errors++;
    $display("MISMATCH %0t wait ran out", $time);
    close_out();
  endtask : wait_for
  task automatic cfg_src(input int s, input logic en, input logic rt, input logic [3:0] pr);
    @(negedge clock);
    src_cfg[s] = '{1'b0, en, rt, s[2:0] & {3{rt}}, pr};
    src_cfg_we[s] = 1'b1;
    @(negedge clock);
    src_cfg_we[s] = 1'b0;
  endtask : cfg_src
  task automatic request(input int s);
    @(negedge clock);
    periph_req[s] = 1'b1;
    @(negedge clock);
    periph_req[s] = 1'b0;
  endtask : request
  task automatic set_limit(input logic up, input logic [15:0] lim);
    @(negedge clock);
    limit_wdata = lim;
    stack_upper_limit_we = up;
    stack_lower_limit_we = !up;
    @(negedge clock);
    stack_upper_limit_we = 1'b0;
    stack_lower_limit_we = 1'b0;
  endtask : set_limit
  task automatic t_vectors();
    for (int s = 0; s < 17; s++) begin
      ack_delay = 4'(s % 4);
      cfg_src(s, 1'b1, 1'b0, 4'h3);
      request(s);
      cmp_val(enable_flag[s], 1, "enable");
      wait_for(0);
      cmp_val(irq_vector, VEC[s], "vector");
      cmp_val(irq_level, 3, "level");
      repeat (8) @(negedge clock);
      cmp_val(req_flag[s], 0, "pending");
      cfg_src(s, 1'b0, 1'b0, 4'h3);
    end
  endtask : t_vectors
  task automatic t_prio();
    cpu_level = 6'h06;
    cfg_src(5, 1'b1, 1'b0, 4'h6);
    request(5);
    repeat (10) @(negedge clock);
    cmp_val(irq_valid, 0, "equal level");
    cpu_level = 6'h05;
    wait_for(0);
    cmp_val(irq_level, 6, "higher level");
    repeat (8) @(negedge clock);
    cpu_level = 6'h00;
  endtask : t_prio
  task automatic t_chan();
    @(negedge clock);
    chan_cfg[4] = '{1'b0, 1'b1, 1'b1, 8'h02, 24'h001000, 24'h002000};
    chan_cfg[0] = '{1'b1, 1'b0, 1'b0, 8'h05, 24'h003000, 24'h004000};
    chan_cfg_we = 8'h11;
    @(negedge clock);
    chan_cfg_we = 8'h00;
    cfg_src(12, 1'b1, 1'b1, 4'h2);
    cfg_src(8, 1'b1, 1'b1, 4'h2);
    for (int k = 0; k < 2; k++) begin
      request(12);
      wait_for(1);
      cmp_val(move.src, 24'h001000, "move src");
      cmp_val(move.dst, k ? 24'h002002 : 24'h002000, "move dst");
      cmp_val(move.word, 1, "word");
      @(negedge clock);
      cmp_val(move.valid, 0, "stolen cycle");
      cmp_val(chan_count[39:32], 1 - k, "count");
    end
    request(12);
    wait_for(0);
    cmp_val(irq_vector, 24'h0000AC, "exhausted");
    repeat (8) @(negedge clock);
    request(8);
    wait_for(1);
    cmp_val({move.word, move.dst}, 25'h0004000, "byte move");
    @(negedge clock);
    cmp_val(chan_count[7:0], 5, "continuous");
  endtask : t_chan
  task automatic t_trap(input logic [15:0] sp, input logic [4:0] cb, input logic nmi,
                        input int b, input logic [23:0] vec);
    @(negedge clock);
    stack_pointer_reg = sp;
    stack_access = 1'b1;
    class_b_event = cb;
    nmi_pin = nmi;
    @(negedge clock);
    stack_access = 1'b0;
    class_b_event = 5'h00;
    wait_for(0);
    cmp_val(irq_vector, vec, "trap vector");
    cmp_val(irq_is_trap, 1, "trap kind");
    cmp_val(trap_flag_register, 32'h1 << b, "trap flag");
    if (b == 14) begin
      cfg_src(1, 1'b1, 1'b0, 4'hF);
      request(1);
      repeat (8) @(negedge clock);
      cmp_val(irq_vector, vec, "held by trap");
    end
    trap_flag_clear[b] = 1'b1;
    nmi_pin = 1'b1;
    @(negedge clock);
    trap_flag_clear = '0;
    repeat (14) @(negedge clock);
    cmp_val({req_flag[1], trap_flag_register}, 0, "cleared");
  endtask : t_trap
  task automatic t_ext();
    // Source 1 stays enabled after the trap test and would be serviced away
    cfg_src(1, 1'b0, 1'b0, 4'hF);
    ext_edge_sel = '{itc_pkg::EDGE_RISE, itc_pkg::EDGE_BOTH, itc_pkg::EDGE_RISE,
                     itc_pkg::EDGE_FALL};
    ext_pin = 4'h7;
    repeat (8) @(negedge clock);
    cmp_val(req_flag[3:0], 4'h6, "rising");
    ext_pin = 4'h0;
    repeat (8) @(negedge clock);
    cmp_val(req_flag[3:0], 4'h7, "falling");
  endtask : t_ext
  task automatic t_sw();
    @(negedge clock);
    cpu_level = 6'h04;
    swtrap_num = 7'h7F;
    swtrap_req = 1'b1;
    @(negedge clock);
    swtrap_req = 1'b0;
    // Software trap offer lasts only the cycle after its strobe
    cmp_val({irq_valid, irq_level, irq_vector}, {1'b1, 6'h04, 24'h0001FC}, "sw trap");
  endtask : t_sw
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    cmp_val({irq_valid, move.valid, req_flag}, 0, "reset");
    cmp_val(trap_flag_register, 0, "reset flags");
    t_vectors();
    t_prio();
    t_chan();
    t_trap(16'hF9FE, 5'h00, 1'b1, 14, 24'h000010);
    set_limit(1'b1, 16'hFB80);
    t_trap(16'hFB40, 5'h00, 1'b1, 14, 24'h000010);
    set_limit(1'b1, 16'hFA00);
    t_trap(16'hFC02, 5'h00, 1'b1, 13, 24'h000018);
    set_limit(1'b0, 16'hFB20);
    t_trap(16'hFB40, 5'h00, 1'b1, 13, 24'h000018);
    set_limit(1'b0, 16'hFC00);
    t_trap(16'hFB00, 5'h00, 1'b0, 15, 24'h000008);
    for (int j = 0; j < 5; j++) begin
      t_trap(16'hFB00, 5'(1 << j), 1'b1, TFB[j], 24'h000028);
    end
    t_ext();
    t_sw();
    close_out();
  end
endmodule : itc_controller_tb_top
